/* File: rtl/mtu_regs.svh */
`ifndef MTU_REGS_SVH
`define MTU_REGS_SVH

// ****************************************************************
// special function register offsets
// ****************************************************************
`define MTU_OFF_PE_STAT      8'h85
`define MTU_OFF_TCTRL        8'h88
`define MTU_OFF_TMODE        8'h89
`define MTU_OFF_T0_LOW       8'h8A
`define MTU_OFF_T1_LOW       8'h8B
`define MTU_OFF_T0_HIGH      8'h8C
`define MTU_OFF_T1_HIGH      8'h8D
`define MTU_OFF_SLOW_CFG     8'h93
`define MTU_OFF_SLOW_TGT_HI  8'h94
`define MTU_OFF_SLOW_TGT_LO  8'h95

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define MTU_STAT_SLOW_BIT    0
`define MTU_CFG_RUN_BIT      0
`define MTU_RST_BYTE         8'h00

// ****************************************************************
// timing counts
// ****************************************************************
`define MTU_SLOW_STEP_CLOCKS 65536

`endif

/* File: rtl/mtu_pkg.sv */
package mtu_pkg;

  // ****************************************************************
  // timer0/1 operating modes
  // ****************************************************************
  typedef enum logic [1:0] {
    MTU_MODE_13BIT  = 2'h0,
    MTU_MODE_16BIT  = 2'h1,
    MTU_MODE_RELOAD = 2'h2,
    MTU_MODE_SPLIT  = 2'h3
  } mtu_mode_e_t;

  // ****************************************************************
  // carriers and register layouts
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mtu_sfr_req_t;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer1_run;
    logic timer0_overflow_flag;
    logic timer0_run;
    logic ext_irq_one_flag;
    logic rsv2;
    logic ext_irq_zero_flag;
    logic rsv0;
  } mtu_tctrl_t;

  typedef struct packed {
    logic [1:0]  rsv76;
    mtu_mode_e_t timer1_mode_field;
    logic [1:0]  rsv32;
    mtu_mode_e_t timer0_mode_field;
  } mtu_tmode_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic       slow_timer_step_select;
    logic       slow_timer_clock_select;
    logic       slow_timer_reload_mode;
    logic       slow_timer_run;
  } mtu_slow_cfg_t;

endpackage : mtu_pkg

/* File: rtl/mtu_timer_pair.sv */
`timescale 1ns/1ps

module mtu_timer_pair #(
  parameter bit SPLIT_EN = 1'b1
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rstn_i,
  input  wire mtu_pkg::mtu_mode_e_t mode_i,
  input  wire logic               run_i,
  input  wire logic               run_hi_i,
  input  wire logic               wr_lo_i,
  input  wire logic               wr_hi_i,
  input  wire logic [7:0]         wdata_i,
  output logic      [7:0]         tl_o,
  output logic      [7:0]         th_o,
  output logic                    ovf_o,
  output logic                    ovf_hi_o
);
  import mtu_pkg::*;

  logic [7:0] next_tl;
  logic [7:0] next_th;

  always_comb begin
    next_tl  = tl_o;
    next_th  = th_o;
    ovf_o    = 1'b0;
    ovf_hi_o = 1'b0;
    case (mode_i)
      MTU_MODE_13BIT: begin
        // upper three bits of the low byte are left alone as a plain store
        if (run_i) begin
          next_tl[4:0] = tl_o[4:0] + 5'h01;
          if (tl_o[4:0] == 5'h1F) begin
            next_th = th_o + 8'h01;
            ovf_o   = (th_o == 8'hFF);
          end
        end
      end
      MTU_MODE_16BIT: begin
        if (run_i) begin
          {next_th, next_tl} = {th_o, tl_o} + 16'h0001;
          ovf_o              = ({th_o, tl_o} == 16'hFFFF);
        end
      end
      MTU_MODE_RELOAD: begin
        if (run_i) begin
          if (tl_o == 8'hFF) begin
            next_tl = th_o;
            ovf_o   = 1'b1;
          end else begin
            next_tl = tl_o + 8'h01;
          end
        end
      end
      default: begin
        // timer1 simply holds in this mode
        if (SPLIT_EN) begin
          if (run_i) begin
            next_tl = tl_o + 8'h01;
            ovf_o   = (tl_o == 8'hFF);
          end
          if (run_hi_i) begin
            next_th  = th_o + 8'h01;
            ovf_hi_o = (th_o == 8'hFF);
          end
        end
      end
    endcase
    // software write takes the byte over from counting
    if (wr_lo_i) begin
      next_tl = wdata_i;
    end
    if (wr_hi_i) begin
      next_th = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tl_o <= 8'h00;
      th_o <= 8'h00;
    end else begin
      tl_o <= next_tl;
      th_o <= next_th;
    end
  end

endmodule : mtu_timer_pair

/* File: rtl/mcu_timer_unit.sv */
`timescale 1ns/1ps
`include "mtu_regs.svh"

// Function
// - timer one runs the mode in bits 5:4
// - timer zero runs the mode in bits 1:0
// - timer one or split high overflow sets flag
// - run bit six gates timer one or split
// - timer zero overflow sets its flag
// - run bit four enables timer zero, else holds, except its split high byte, which runs on bit six
// - external flags set by hardware, software clears
// - slow step every clock or every 65536
// - slow clock from rc or crystal
// - status bit zero; config write clears it
// - reload bit picks automatic or manual mode
// - manual stops and clears run; automatic restarts
// - writing run one while counting restarts
// - target bytes; writing either while counting restarts
module mcu_timer_unit #(
  parameter int SLOW_STEP_CLOCKS = `MTU_SLOW_STEP_CLOCKS
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  input  wire mtu_pkg::mtu_sfr_req_t sfr_req_i,
  input  wire logic                  ext_irq_zero_event_i,
  input  wire logic                  ext_irq_one_event_i,
  input  wire logic                  low_speed_rc_clock_i,
  input  wire logic                  xtal_clock_i,
  output logic      [7:0]            sfr_rdata_o,
  output logic                       timer0_overflow_flag_o,
  output logic                       timer1_overflow_flag_o,
  output logic                       slow_timer_irq_status_o
);
  import mtu_pkg::*;

  localparam logic [15:0] SLOW_PRE_LAST = 16'(SLOW_STEP_CLOCKS - 1);

  // ****************************************************************
  // state
  // ****************************************************************
  mtu_tctrl_t    tctrl,  next_tctrl;
  mtu_tmode_t    tmode,  next_tmode;
  mtu_slow_cfg_t scfg,   next_scfg;
  logic          slow_timer_irq_status, next_slow_timer_irq_status;
  logic [7:0]    slow_timer_target_high, next_slow_timer_target_high;
  logic [7:0]    slow_timer_target_low,  next_slow_timer_target_low;
  logic [15:0]   slow_count, next_slow_count;
  logic [15:0]   slow_pre,   next_slow_pre;
  logic          slow_prev,  next_slow_prev;
  logic [7:0]    next_rdata;

  logic wr_stat, wr_tctrl, wr_tmode, wr_t0l, wr_t1l, wr_t0h, wr_t1h;
  logic wr_scfg, wr_thi, wr_tlo;
  logic [7:0] tl0, th0, tl1, th1;
  logic t0_ovf, t0_ovf_hi, t1_ovf, t0_split;
  logic slow_level, slow_tick, slow_step, slow_hit;

  assign t0_split = (tmode.timer0_mode_field == MTU_MODE_SPLIT);

  // ****************************************************************
  // address decode
  // ****************************************************************
  always_comb begin
    wr_stat  = 1'b0;
    wr_tctrl = 1'b0;
    wr_tmode = 1'b0;
    wr_t0l   = 1'b0;
    wr_t1l   = 1'b0;
    wr_t0h   = 1'b0;
    wr_t1h   = 1'b0;
    wr_scfg  = 1'b0;
    wr_thi   = 1'b0;
    wr_tlo   = 1'b0;
    if (sfr_req_i.wr) begin
      if (sfr_req_i.addr == `MTU_OFF_PE_STAT) begin
        wr_stat = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_TCTRL) begin
        wr_tctrl = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_TMODE) begin
        wr_tmode = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_T0_LOW) begin
        wr_t0l = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_T1_LOW) begin
        wr_t1l = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_T0_HIGH) begin
        wr_t0h = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_T1_HIGH) begin
        wr_t1h = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_SLOW_CFG) begin
        wr_scfg = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_SLOW_TGT_HI) begin
        wr_thi = 1'b1;
      end else if (sfr_req_i.addr == `MTU_OFF_SLOW_TGT_LO) begin
        wr_tlo = 1'b1;
      end
    end
  end

  // ****************************************************************
  // timer0 and timer1
  // ****************************************************************
  mtu_timer_pair #(.SPLIT_EN(1'b1)) u_timer0 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .mode_i    (tmode.timer0_mode_field),
    .run_i     (tctrl.timer0_run),
    .run_hi_i  (tctrl.timer1_run),
    .wr_lo_i   (wr_t0l),
    .wr_hi_i   (wr_t0h),
    .wdata_i   (sfr_req_i.wdata),
    .tl_o      (tl0),
    .th_o      (th0),
    .ovf_o     (t0_ovf),
    .ovf_hi_o  (t0_ovf_hi)
  );

  // run bit belongs to timer0's high half while timer0 is split
  mtu_timer_pair #(.SPLIT_EN(1'b0)) u_timer1 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .mode_i    (tmode.timer1_mode_field),
    .run_i     (tctrl.timer1_run & ~t0_split),
    .run_hi_i  (1'b0),
    .wr_lo_i   (wr_t1l),
    .wr_hi_i   (wr_t1h),
    .wdata_i   (sfr_req_i.wdata),
    .tl_o      (tl1),
    .th_o      (th1),
    .ovf_o     (t1_ovf),
    .ovf_hi_o  ()
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_tctrl                  = tctrl;
    next_tmode                  = tmode;
    next_scfg                   = scfg;
    next_slow_timer_irq_status  = slow_timer_irq_status;
    next_slow_timer_target_high = slow_timer_target_high;
    next_slow_timer_target_low  = slow_timer_target_low;
    next_slow_count             = slow_count;
    next_slow_pre               = slow_pre;
    slow_step                   = 1'b0;
    slow_hit                    = 1'b0;
    // control bytes: software first, hardware sets win afterwards
    if (wr_tctrl) begin
      next_tctrl      = mtu_tctrl_t'(sfr_req_i.wdata);
      next_tctrl.rsv2 = 1'b0;
      next_tctrl.rsv0 = 1'b0;
    end
    if (wr_tmode) begin
      next_tmode = mtu_tmode_t'({2'h0, sfr_req_i.wdata[5:4], 2'h0, sfr_req_i.wdata[1:0]});
    end
    if (t1_ovf || t0_ovf_hi) begin
      next_tctrl.timer1_overflow_flag = 1'b1;
    end
    if (t0_ovf) begin
      next_tctrl.timer0_overflow_flag = 1'b1;
    end
    if (ext_irq_one_event_i) begin
      next_tctrl.ext_irq_one_flag = 1'b1;
    end
    if (ext_irq_zero_event_i) begin
      next_tctrl.ext_irq_zero_flag = 1'b1;
    end
    // slow clock is a plain synchronous input, so a rising edge is one tick
    slow_level     = scfg.slow_timer_clock_select ? xtal_clock_i
                                                  : low_speed_rc_clock_i;
    slow_tick      = slow_level & ~slow_prev;
    next_slow_prev = slow_level;
    if (scfg.slow_timer_run && slow_tick) begin
      if (scfg.slow_timer_step_select) begin
        slow_step     = (slow_pre == SLOW_PRE_LAST);
        next_slow_pre = slow_step ? 16'h0000 : slow_pre + 16'h0001;
      end else begin
        slow_step = 1'b1;
      end
    end
    if (slow_step) begin
      if (slow_count == {slow_timer_target_high, slow_timer_target_low}) begin
        slow_hit        = 1'b1;
        next_slow_count = 16'h0000;
        if (!scfg.slow_timer_reload_mode) begin
          next_scfg.slow_timer_run = 1'b0;
        end
      end else begin
        next_slow_count = slow_count + 16'h0001;
      end
    end
    if (wr_thi) begin
      next_slow_timer_target_high = sfr_req_i.wdata;
    end
    if (wr_tlo) begin
      next_slow_timer_target_low = sfr_req_i.wdata;
    end
    if ((wr_thi || wr_tlo) && scfg.slow_timer_run) begin
      next_slow_count = 16'h0000;
      next_slow_pre   = 16'h0000;
    end
    if (wr_scfg) begin
      next_scfg = mtu_slow_cfg_t'({4'h0, sfr_req_i.wdata[3:0]});
      if (sfr_req_i.wdata[`MTU_CFG_RUN_BIT]) begin
        next_slow_count = 16'h0000;
        next_slow_pre   = 16'h0000;
      end
    end
    if (wr_stat) begin
      next_slow_timer_irq_status = sfr_req_i.wdata[`MTU_STAT_SLOW_BIT];
    end
    if (wr_scfg) begin
      next_slow_timer_irq_status = 1'b0;
    end
    if (slow_hit) begin
      next_slow_timer_irq_status = 1'b1;
    end
    // read data, unmapped offsets answer zero
    next_rdata = `MTU_RST_BYTE;
    if (sfr_req_i.rd) begin
      if (sfr_req_i.addr == `MTU_OFF_PE_STAT) begin
        next_rdata = {7'h00, slow_timer_irq_status};
      end else if (sfr_req_i.addr == `MTU_OFF_TCTRL) begin
        next_rdata = tctrl;
      end else if (sfr_req_i.addr == `MTU_OFF_TMODE) begin
        next_rdata = tmode;
      end else if (sfr_req_i.addr == `MTU_OFF_T0_LOW) begin
        next_rdata = tl0;
      end else if (sfr_req_i.addr == `MTU_OFF_T1_LOW) begin
        next_rdata = tl1;
      end else if (sfr_req_i.addr == `MTU_OFF_T0_HIGH) begin
        next_rdata = th0;
      end else if (sfr_req_i.addr == `MTU_OFF_T1_HIGH) begin
        next_rdata = th1;
      end else if (sfr_req_i.addr == `MTU_OFF_SLOW_CFG) begin
        next_rdata = scfg;
      end else if (sfr_req_i.addr == `MTU_OFF_SLOW_TGT_HI) begin
        next_rdata = slow_timer_target_high;
      end else if (sfr_req_i.addr == `MTU_OFF_SLOW_TGT_LO) begin
        next_rdata = slow_timer_target_low;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tctrl                  <= mtu_tctrl_t'(`MTU_RST_BYTE);
      tmode                  <= mtu_tmode_t'(`MTU_RST_BYTE);
      scfg                   <= mtu_slow_cfg_t'(`MTU_RST_BYTE);
      slow_timer_irq_status  <= 1'b0;
      slow_timer_target_high <= `MTU_RST_BYTE;
      slow_timer_target_low  <= `MTU_RST_BYTE;
      slow_count             <= 16'h0000;
      slow_pre               <= 16'h0000;
      slow_prev              <= 1'b0;
      sfr_rdata_o            <= `MTU_RST_BYTE;
    end else begin
      tctrl                  <= next_tctrl;
      tmode                  <= next_tmode;
      scfg                   <= next_scfg;
      slow_timer_irq_status  <= next_slow_timer_irq_status;
      slow_timer_target_high <= next_slow_timer_target_high;
      slow_timer_target_low  <= next_slow_timer_target_low;
      slow_count             <= next_slow_count;
      slow_pre               <= next_slow_pre;
      slow_prev              <= next_slow_prev;
      sfr_rdata_o            <= next_rdata;
    end
  end

  assign timer0_overflow_flag_o  = tctrl.timer0_overflow_flag;
  assign timer1_overflow_flag_o  = tctrl.timer1_overflow_flag;
  assign slow_timer_irq_status_o = slow_timer_irq_status;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  a_t0_flag_set: assert property (t0_ovf |=> tctrl.timer0_overflow_flag)
    else $error("timer0 overflow did not set its flag");
  a_t1_flag_set: assert property ((t1_ovf || t0_ovf_hi) |=> tctrl.timer1_overflow_flag)
    else $error("timer1 flag missed an overflow");
  a_t0_hold_idle: assert property ((!tctrl.timer0_run && !t0_split && !wr_t0l && !wr_t0h)
    |=> $stable({th0, tl0}))
    else $error("timer0 moved while stopped");
  a_t1_count_16: assert property ((tmode.timer1_mode_field == MTU_MODE_16BIT
    && tctrl.timer1_run && !t0_split && !wr_t1l && !wr_t1h && {th1, tl1} != 16'hFFFF)
    |=> {th1, tl1} == $past({th1, tl1}) + 16'h0001)
    else $error("timer1 16-bit count did not advance by one");
  a_t0_reload_low: assert property ((tmode.timer0_mode_field == MTU_MODE_RELOAD
    && tctrl.timer0_run && tl0 == 8'hFF && !wr_t0l && !wr_t0h)
    |=> tl0 == $past(th0) && tctrl.timer0_overflow_flag)
    else $error("timer0 low byte not reloaded from high byte");
  a_ext_flag_sticky: assert property (ext_irq_zero_event_i |=> tctrl.ext_irq_zero_flag
    ##1 (tctrl.ext_irq_zero_flag || $past(wr_tctrl)))
    else $error("external flag lost without software clear");
  a_slow_cfg_clear: assert property ((wr_scfg && !slow_hit) |=> !slow_timer_irq_status)
    else $error("config write did not clear slow status");
  a_slow_manual_stop: assert property ((slow_hit && !scfg.slow_timer_reload_mode && !wr_scfg)
    |=> !scfg.slow_timer_run && slow_timer_irq_status && slow_count == 16'h0000)
    else $error("manual reload did not stop with status");
  a_slow_auto_keep: assert property ((slow_hit && scfg.slow_timer_reload_mode && !wr_scfg)
    |=> scfg.slow_timer_run && slow_count == 16'h0000)
    else $error("automatic reload did not keep running");
  a_slow_restart_run: assert property ((wr_scfg && sfr_req_i.wdata[0] && scfg.slow_timer_run)
    |=> slow_count == 16'h0000 && slow_pre == 16'h0000)
    else $error("run rewrite did not restart count");
  a_slow_target_restart: assert property (((wr_thi || wr_tlo) && scfg.slow_timer_run)
    |=> slow_count == 16'h0000)
    else $error("target write did not restart count");
  a_slow_single_step: assert property ((slow_tick && scfg.slow_timer_run
    && !scfg.slow_timer_step_select && !slow_hit && !wr_scfg && !wr_thi && !wr_tlo)
    |=> slow_count == $past(slow_count) + 16'h0001)
    else $error("slow timer did not step once per tick");

endmodule : mcu_timer_unit

/* File: test/mcu_timer_unit_bench.sv */
`timescale 1ns/1ps
`include "mtu_regs.svh"

module mcu_timer_unit_bench;
  import mtu_pkg::*;

  localparam int STEP = 4;

  logic         ref_clk_i;
  logic         rstn_i;
  mtu_sfr_req_t req;
  logic         evt0;
  logic         evt1;
  logic         rc;
  logic         xtal;
  logic [7:0]   rdata;
  logic         tf0;
  logic         tf1;
  logic         st;
  logic [7:0]   d;
  logic [7:0]   addrs [11];
  int           n_mismatch;
  int           tests_run;
  int           cyc;
  int           seed;
  int           m_lo;
  int           m_hi;
  int           m_ovf;

  mcu_timer_unit #(.SLOW_STEP_CLOCKS(STEP)) uut (
    .ref_clk_i               (ref_clk_i),
    .rstn_i                  (rstn_i),
    .sfr_req_i               (req),
    .ext_irq_zero_event_i    (evt0),
    .ext_irq_one_event_i     (evt1),
    .low_speed_rc_clock_i    (rc),
    .xtal_clock_i            (xtal),
    .sfr_rdata_o             (rdata),
    .timer0_overflow_flag_o  (tf0),
    .timer1_overflow_flag_o  (tf1),
    .slow_timer_irq_status_o (st)
  );

  // ****************************************************************
  // clock, timeout and common tasks
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // whole run needs well under a thousand cycles; ceiling leaves wide margin
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("BAD %0t run did not finish", $time);
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cycles

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    @(posedge ref_clk_i);
    req <= '0;
    // callers look at outputs next, so let the write edge settle first
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge ref_clk_i);
    req <= '0;
    #1 v = rdata;
  endtask : rd

  // ****************************************************************
  // reference model of timer 0/1 counting
  // ****************************************************************
  task automatic tmodel(input int mode, input int k, input bit hi_half);
    int v;
    m_ovf = 0;
    for (int i = 1; i <= k; i++) begin
      if (hi_half) begin
        v = m_hi + 1;
        if (v == 256 && m_ovf == 0) m_ovf = i;
        m_hi = v % 256;
      end else begin
        case (mode)
          0: begin
            v = m_hi * 32 + m_lo % 32 + 1;
            if (v == 8192 && m_ovf == 0) m_ovf = i;
            v = v % 8192;
            m_hi = v / 32;
            m_lo = (m_lo / 32) * 32 + v % 32;
          end
          1: begin
            v = m_hi * 256 + m_lo + 1;
            if (v == 65536 && m_ovf == 0) m_ovf = i;
            m_hi = (v / 256) % 256;
            m_lo = v % 256;
          end
          2: begin
            v = m_lo + 1;
            if (v == 256 && m_ovf == 0) m_ovf = i;
            m_lo = (v == 256) ? m_hi : v;
          end
          4: begin
            // timer one parks while in its own split mode
            v = m_lo;
          end
          default: begin
            v = m_lo + 1;
            if (v == 256 && m_ovf == 0) m_ovf = i;
            m_lo = v % 256;
          end
        endcase
      end
    end
  endtask : tmodel

  task automatic tcase(input logic [7:0] timer_mode_select, input logic [7:0] run, input int mode,
                       input bit hi_half, input logic [7:0] lo, input logic [7:0] hi,
                       input bit t1);
    logic [7:0] alo;
    logic [7:0] ahi;
    logic       f;
    int         k;
    alo = t1 ? `MTU_OFF_T1_LOW : `MTU_OFF_T0_LOW;
    ahi = t1 ? `MTU_OFF_T1_HIGH : `MTU_OFF_T0_HIGH;
    k = (run == 8'h00) ? 0 : 10;
    wr(`MTU_OFF_TCTRL, 8'h00);
    wr(`MTU_OFF_TMODE, timer_mode_select);
    wr(alo, lo);
    wr(ahi, hi);
    wr(`MTU_OFF_TCTRL, run);
    cycles(10);
    #1 f = (t1 || hi_half) ? tf1 : tf0;
    m_lo = lo;
    m_hi = hi;
    tmodel(mode, k, hi_half);
    chk({7'h00, f}, {7'h00, m_ovf != 0}, "overflow flag");
    wr(`MTU_OFF_TCTRL, 8'h00);
    m_lo = lo;
    m_hi = hi;
    tmodel(mode, k ? 12 : 0, hi_half);
    rd(alo, d);
    chk(d, 8'(m_lo), "count low");
    rd(ahi, d);
    chk(d, 8'(m_hi), "count high");
    $display("timer case timer_mode_select %h run %h done", timer_mode_select, run);
  endtask : tcase

  // ****************************************************************
  // slow clock ticks
  // ****************************************************************
  // selected input rises once per tick, the other twice, so a wrong selection doubles the count
  task automatic tick(input bit x);
    @(posedge ref_clk_i);
    xtal <= 1'b1;
    rc   <= 1'b1;
    cycles(2);
    xtal <= x;
    rc   <= !x;
    cycles(2);
    xtal <= !x;
    rc   <= x;
    cycles(2);
    xtal <= 1'b0;
    rc   <= 1'b0;
    cycles(2);
  endtask : tick

  task automatic ticks(input bit x, input int n);
    repeat (n) tick(x);
  endtask : ticks

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rstn_i = 1'b0;
    req = '0;
    evt0 = 1'b0;
    evt1 = 1'b0;
    rc = 1'b0;
    xtal = 1'b0;
    seed = 42;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    addrs = '{8'h85, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h93, 8'h94, 8'h95, 8'h86};
    cycles(8);
    rstn_i <= 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i], d);
      chk(d, 8'h00, "reset value");
    end
    wr(`MTU_OFF_TMODE, 8'hFF);
    rd(`MTU_OFF_TMODE, d);
    chk(d, 8'h33, "mode reserved bits");
    wr(`MTU_OFF_PE_STAT, 8'hFF);
    rd(`MTU_OFF_PE_STAT, d);
    chk(d, 8'h01, "status reserved bits");
    wr(8'h86, 8'hFF);
    rd(8'h86, d);
    chk(d, 8'h00, "unmapped read");
    wr(`MTU_OFF_SLOW_CFG, 8'hF0);
    chk({7'h00, st}, 8'h00, "config write clears status");
    $display("register test done");

    for (int m = 0; m < 4; m++) tcase(8'(m), 8'h10, m, 0, 8'hFC, (m == 2) ? 8'hF0 : 8'hFF, 0);
    for (int m = 0; m < 4; m++)
      tcase(8'(m << 4), 8'h40, (m == 3) ? 4 : m, 0, 8'hFC, (m == 2) ? 8'hF0 : 8'hFF, 1);
    tcase(8'h03, 8'h40, 3, 1, 8'h00, 8'hFC, 0);
    tcase(8'h01, 8'h00, 1, 0, 8'hFC, 8'hFF, 0);
    tcase(8'h01, 8'h10, 1, 0, 8'($random(seed)), 8'($random(seed)), 0);

    @(posedge ref_clk_i);
    evt0 <= 1'b1;
    @(posedge ref_clk_i);
    evt0 <= 1'b0;
    rd(`MTU_OFF_TCTRL, d);
    chk(d, 8'h02, "ext zero flag");
    @(posedge ref_clk_i);
    evt1 <= 1'b1;
    @(posedge ref_clk_i);
    evt1 <= 1'b0;
    cycles(5);
    rd(`MTU_OFF_TCTRL, d);
    chk(d, 8'h0A, "ext flags held");
    wr(`MTU_OFF_TCTRL, 8'h00);
    rd(`MTU_OFF_TCTRL, d);
    chk(d, 8'h00, "ext flags cleared");
    $display("external flag test done");

    for (int r = 0; r < 2; r++) begin
      wr(`MTU_OFF_SLOW_TGT_LO, 8'h02);
      wr(`MTU_OFF_SLOW_TGT_HI, 8'h00);
      wr(`MTU_OFF_SLOW_CFG, 8'h01);
      ticks(0, 2);
      if (r == 1) wr(`MTU_OFF_SLOW_TGT_LO, 8'h02);
      else wr(`MTU_OFF_SLOW_CFG, 8'h01);
      ticks(0, 2);
      chk({7'h00, st}, 8'h00, "status early after restart");
      ticks(0, 1);
      chk({7'h00, st}, 8'h01, "status at target");
      rd(`MTU_OFF_PE_STAT, d);
      chk(d, 8'h01, "status register");
      rd(`MTU_OFF_SLOW_CFG, d);
      chk(d, 8'h00, "manual run cleared");
      wr(`MTU_OFF_SLOW_CFG, 8'h00);
      chk({7'h00, st}, 8'h00, "config write clears");
    end
    $display("manual slow timer test done");

    wr(`MTU_OFF_SLOW_TGT_LO, 8'h01);
    wr(`MTU_OFF_SLOW_CFG, 8'h0F);
    for (int r = 0; r < 2; r++) begin
      ticks(1, 2 * STEP - 1);
      chk({7'h00, st}, 8'h00, "auto status early");
      ticks(1, 1);
      chk({7'h00, st}, 8'h01, "auto status at target");
      rd(`MTU_OFF_SLOW_CFG, d);
      chk(d, 8'h0F, "auto run kept");
      wr(`MTU_OFF_SLOW_CFG, 8'h0F);
    end
    wr(`MTU_OFF_SLOW_CFG, 8'h00);
    $display("auto slow timer test done");
    stop_test();
  end

endmodule : mcu_timer_unit_bench
